// ### core/flg_guard.sv
// Purpose: Flash lock regions, security bit and debug access gating.
// Assumes: Avalon-MM slave with one wait cycle; flash array on same clock.
// Notes: Calibration word and unique identifier defaults are arbitrary.
// Behaviour
// - Flash splits into 16 kbyte regions of 64 pages, one lock bit each.
// - Program or page erase on a locked region aborts and raises the interrupt.
// - Set-lock and clear-lock commands change one region's lock bit.
// - A qualified erase pin clears every lock bit.
// - Security state is general purpose nonvolatile bit 0.
// - While secure, debug and fast programming accesses are refused.
// - Only the set bit 0 command sets security; no command clears it.
// - Security clears only after erase pin then a full flash erase.
// - With security off, every access path is granted again.
// - Calibration bits are fixed and ignore the erase pin.
// - The 128-bit unique identifier is fixed and ignores the erase pin.
// - A command returns a descriptor word of the flash organisation.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`include "flg_map.svh"
`default_nettype none
module flg_guard #(
  parameter int unsigned NUM_REGIONS = 16,
  parameter int unsigned ERASE_QUAL_CYC =
    (`FLG_ERASE_FILTER_NS + `FLG_CLK_PERIOD_NS - 1) / `FLG_CLK_PERIOD_NS,
  parameter logic [31:0] CALIB_WORD = 32'h0000_5A5A,
  parameter logic [127:0] UNIQUE_ID =
    128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire flg_pkg::flg_word_t avs_writedata_in,
  output var flg_pkg::flg_word_t avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic erase_pin_in,
  input wire logic nvm_secure_in,
  input wire logic [NUM_REGIONS-1:0] nvm_lock_in,
  input wire logic flash_done_in,
  input wire logic dbg_req_in,
  input wire logic ffpi_req_in,
  output logic dbg_grant_out,
  output logic ffpi_grant_out,
  output logic flash_start_out,
  output logic [1:0] flash_op_out,
  output logic [15:0] flash_page_out,
  output logic [3:0] flash_wait_out,
  output logic [NUM_REGIONS-1:0] lock_bits_out,
  output logic secure_out,
  output logic irq_out
);
  import flg_pkg::*;

  localparam int unsigned RW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;
  localparam int unsigned CW = $clog2(ERASE_QUAL_CYC + 1);
  localparam logic [CW-1:0] QUAL_LAST = CW'(ERASE_QUAL_CYC - 1);
  localparam logic [9:0] REGION_COUNT = 10'(NUM_REGIONS);

  flg_state_e state;
  flg_word_t read_mux;
  flg_word_t result;
  logic loaded;
  logic lock_err;
  logic cmd_err;
  logic erase_s1;
  logic erase_s2;
  logic [CW-1:0] erase_cnt;
  logic erase_qual;
  logic erase_armed;
  logic erase_pend;
  logic cur_all;
  logic acc_wr;
  logic acc_rd;
  logic cmd_sel;
  logic cmd_go;
  logic [7:0] cmd_key;
  logic [15:0] cmd_page;
  logic [9:0] region;
  logic region_ok;
  logic hit_lock;
  logic page_cmd;
  logic region_cmd;
  logic known_cmd;
  logic op_ok;
  logic lock_abort;
  logic bad_cmd;
  logic launch;
  logic full_done;
  logic st_clr;

  // Requests complete at the edge where waitrequest is seen low.
  assign acc_wr = avs_write_in & ~avs_waitrequest_out;
  assign acc_rd = avs_read_in & ~avs_waitrequest_out;
  assign cmd_sel = acc_wr && (avs_address_in == `FLG_REG_CMD);
  assign st_clr = acc_rd && (avs_address_in == `FLG_REG_STATUS);
  assign cmd_key = avs_writedata_in[7:0];
  assign cmd_page = avs_writedata_in[31:16];
  // Region index is the page number over the pages per region.
  assign region = cmd_page[15:`FLG_PAGES_PER_REGION_LOG2];
  assign region_ok = region < REGION_COUNT;
  assign hit_lock = region_ok && lock_bits_out[region[RW-1:0]];
  assign page_cmd = (cmd_key == `FLG_CMD_PROG) ||
                    (cmd_key == `FLG_CMD_ERASE_PAGE);
  assign region_cmd = page_cmd || (cmd_key == `FLG_CMD_SET_LOCK) ||
                      (cmd_key == `FLG_CMD_CLR_LOCK);
  assign known_cmd = region_cmd || (cmd_key == `FLG_CMD_ERASE_ALL) ||
                     (cmd_key == `FLG_CMD_SET_GP) ||
                     (cmd_key == `FLG_CMD_GET_DESC);
  // A command is refused while busy, while a pin erase waits, or on a
  // partial write, so a half-written key can never start an operation.
  assign cmd_go = cmd_sel && (avs_byteenable_in == 4'hF) && loaded &&
                  (state == flg_st_idle) && !erase_pend;
  assign op_ok = cmd_go && page_cmd && region_ok && !hit_lock;
  assign lock_abort = cmd_go && page_cmd && hit_lock;
  assign bad_cmd = (cmd_sel && !cmd_go) ||
                   (cmd_go && (!known_cmd || (region_cmd && !region_ok) ||
                    ((cmd_key == `FLG_CMD_SET_GP) && (cmd_page != 16'h0000))));
  assign launch = op_ok || (cmd_go && (cmd_key == `FLG_CMD_ERASE_ALL)) ||
                  ((state == flg_st_idle) && erase_pend);
  assign full_done = (state == flg_st_busy) && flash_done_in && cur_all;
  assign erase_qual = erase_s2 && (erase_cnt == QUAL_LAST);

  always_comb begin
    read_mux = `FLG_RESET_WORD;
    case (avs_address_in)
      `FLG_REG_CMD: read_mux = `FLG_RESET_WORD;
      `FLG_REG_STATUS: begin
        read_mux[`FLG_ST_READY] = (state == flg_st_idle) && !erase_pend;
        read_mux[`FLG_ST_LOCK_ERR] = lock_err;
        read_mux[`FLG_ST_CMD_ERR] = cmd_err;
        read_mux[`FLG_ST_SECURE] = secure_out;
      end
      `FLG_REG_LOCK: read_mux[NUM_REGIONS-1:0] = lock_bits_out;
      `FLG_REG_RESULT: read_mux = result;
      `FLG_REG_CTRL: read_mux[3:0] = flash_wait_out;
      `FLG_REG_CALIB: read_mux = CALIB_WORD;
      `FLG_REG_UID0: read_mux = UNIQUE_ID[31:0];
      `FLG_REG_UID1: read_mux = UNIQUE_ID[63:32];
      `FLG_REG_UID2: read_mux = UNIQUE_ID[95:64];
      `FLG_REG_UID3: read_mux = UNIQUE_ID[127:96];
      default: read_mux = `FLG_RESET_WORD;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= `FLG_RESET_WORD;
    end else begin
      avs_waitrequest_out <= 1'b1;
      if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        if (avs_read_in) begin
          avs_readdata_out <= read_mux;
        end
      end
    end
  end

  // Wait states are only stored; the array controller applies them.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      flash_wait_out <= 4'h0;
    end else if (acc_wr && (avs_address_in == `FLG_REG_CTRL) &&
                 avs_byteenable_in[0]) begin
      flash_wait_out <= avs_writedata_in[3:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      erase_s1 <= 1'b0;
      erase_s2 <= 1'b0;
      erase_cnt <= '0;
    end else begin
      erase_s1 <= erase_pin_in;
      erase_s2 <= erase_s1;
      if (!erase_s2) begin
        erase_cnt <= '0;
      end else if (erase_cnt != CW'(ERASE_QUAL_CYC)) begin
        erase_cnt <= erase_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      erase_armed <= 1'b0;
      erase_pend <= 1'b0;
    end else begin
      if (erase_qual) begin
        erase_armed <= 1'b1;
      end else if (full_done) begin
        erase_armed <= 1'b0;
      end
      if (erase_qual) begin
        erase_pend <= 1'b1;
      end else if (state == flg_st_idle) begin
        erase_pend <= 1'b0;
      end
    end
  end

  // Locks and security start closed and take the stored copy one cycle
  // after reset, so nothing slips through before the copy is known.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      loaded <= 1'b0;
      lock_bits_out <= '1;
    end else begin
      loaded <= 1'b1;
      if (!loaded) begin
        lock_bits_out <= nvm_lock_in;
      end else if (erase_qual) begin
        lock_bits_out <= '0;
      end else if (cmd_go && region_ok &&
                   (cmd_key == `FLG_CMD_SET_LOCK)) begin
        lock_bits_out[region[RW-1:0]] <= 1'b1;
      end else if (cmd_go && region_ok &&
                   (cmd_key == `FLG_CMD_CLR_LOCK)) begin
        lock_bits_out[region[RW-1:0]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      secure_out <= 1'b1;
    end else if (!loaded) begin
      secure_out <= nvm_secure_in;
    end else if (cmd_go && (cmd_key == `FLG_CMD_SET_GP) &&
                 (cmd_page == 16'h0000)) begin
      secure_out <= 1'b1;
    end else if (full_done && erase_armed) begin
      secure_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      dbg_grant_out <= 1'b0;
      ffpi_grant_out <= 1'b0;
    end else begin
      dbg_grant_out <= dbg_req_in && !secure_out && loaded;
      ffpi_grant_out <= ffpi_req_in && !secure_out && loaded;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state <= flg_st_idle;
      flash_start_out <= 1'b0;
      flash_op_out <= 2'h0;
      flash_page_out <= 16'h0000;
      cur_all <= 1'b0;
    end else begin
      flash_start_out <= 1'b0;
      case (state)
        flg_st_idle: begin
          if (launch) begin
            state <= flg_st_busy;
            flash_start_out <= 1'b1;
            if (op_ok) begin
              flash_page_out <= cmd_page;
              flash_op_out <= (cmd_key == `FLG_CMD_PROG) ?
                              `FLG_OP_PROG : `FLG_OP_ERASE_PAGE;
              cur_all <= 1'b0;
            end else begin
              flash_page_out <= 16'h0000;
              flash_op_out <= `FLG_OP_ERASE_ALL;
              cur_all <= 1'b1;
            end
          end
        end
        flg_st_busy: begin
          if (flash_done_in) begin
            state <= flg_st_idle;
          end
        end
        default: state <= flg_st_idle;
      endcase
    end
  end

  // Reading status clears only the bits it returned; a new event wins.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      lock_err <= 1'b0;
      cmd_err <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      lock_err <= lock_abort ||
        (lock_err && !(st_clr && avs_readdata_out[`FLG_ST_LOCK_ERR]));
      cmd_err <= bad_cmd ||
        (cmd_err && !(st_clr && avs_readdata_out[`FLG_ST_CMD_ERR]));
      irq_out <= lock_abort ||
        (lock_err && !(st_clr && avs_readdata_out[`FLG_ST_LOCK_ERR]));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      result <= `FLG_RESET_WORD;
    end else if (cmd_go && (cmd_key == `FLG_CMD_GET_DESC)) begin
      case (cmd_page[1:0])
        2'h0: result <= 32'(NUM_REGIONS);
        2'h1: result <= `FLG_REGION_BYTES;
        2'h2: result <= `FLG_PAGES_PER_REGION;
        default: result <= `FLG_PAGE_BYTES;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_LOCK_ABORT: assert property (
    lock_abort |=> (!flash_start_out && lock_err && irq_out))
    else $error("Locked region command was not aborted.");
  AST_REGION_MAP: assert property (
    op_ok |=> (flash_start_out &&
      (flash_page_out[15:`FLG_PAGES_PER_REGION_LOG2] == $past(region))))
    else $error("Region index does not follow the page number.");
  AST_SET_LOCK: assert property (
    (cmd_go && region_ok && !erase_qual &&
     (cmd_key == `FLG_CMD_SET_LOCK)) |=> lock_bits_out[$past(region[RW-1:0])])
    else $error("Set lock did not set the bit.");
  AST_CLR_LOCK: assert property (
    (cmd_go && region_ok && (cmd_key == `FLG_CMD_CLR_LOCK))
      |=> !lock_bits_out[$past(region[RW-1:0])])
    else $error("Clear lock did not clear the bit.");
  AST_PIN_UNLOCK: assert property (
    (loaded && erase_qual) |=> ((lock_bits_out == '0) && erase_armed))
    else $error("Erase pin did not unlock the flash.");
  AST_SEC_LOAD: assert property (
    !loaded |=> (secure_out == $past(nvm_secure_in)))
    else $error("Security did not load from bit 0.");
  AST_DENY: assert property (
    secure_out |=> (!dbg_grant_out && !ffpi_grant_out))
    else $error("Access granted while secure.");
  AST_SEC_SET: assert property (
    (loaded && $rose(secure_out)) |->
      ($past(cmd_go) && ($past(cmd_key) == `FLG_CMD_SET_GP)))
    else $error("Security set by something else.");
  AST_SEC_CLR: assert property (
    ($past(loaded) && $fell(secure_out)) |->
      ($past(full_done) && $past(erase_armed)))
    else $error("Security cleared without pin and full erase.");
  AST_GRANT: assert property (
    (loaded && !secure_out && dbg_req_in) |=> dbg_grant_out)
    else $error("Access not granted with security off.");
  AST_FIXED: assert property (
    (acc_rd && (avs_address_in == `FLG_REG_UID3)) |->
      (avs_readdata_out == UNIQUE_ID[127:96]))
    else $error("Unique identifier read back wrong.");
  AST_FILTER: assert property (
    $rose(erase_armed) |-> ($past(erase_s2, 1) && $past(erase_s2, 2)))
    else $error("Erase pin acted on without qualification.");

  COV_ABORT: cover property (lock_abort ##1 irq_out);
  COV_UNSECURE: cover property ($fell(secure_out));
  COV_PROG: cover property (op_ok ##1 flash_start_out);
  COV_DESC: cover property (cmd_go && (cmd_key == `FLG_CMD_GET_DESC));
endmodule
`default_nettype wire

// ### core/flg_map.svh
// Purpose: Offsets, fields, codes and timing of the flash lock guard.
// Assumes: Included by the guard module and the testbench only.
// Notes: Register offsets are byte addresses of 32-bit words.
`ifndef FLG_MAP_SVH
`define FLG_MAP_SVH
`define FLG_CLK_PERIOD_NS 50
`define FLG_ERASE_FILTER_NS 1000000
`define FLG_REG_CMD 8'h00
`define FLG_REG_STATUS 8'h04
`define FLG_REG_LOCK 8'h08
`define FLG_REG_RESULT 8'h0C
`define FLG_REG_CTRL 8'h10
`define FLG_REG_CALIB 8'h14
`define FLG_REG_UID0 8'h20
`define FLG_REG_UID1 8'h24
`define FLG_REG_UID2 8'h28
`define FLG_REG_UID3 8'h2C
`define FLG_CMD_PROG 8'h01
`define FLG_CMD_ERASE_PAGE 8'h02
`define FLG_CMD_ERASE_ALL 8'h03
`define FLG_CMD_SET_LOCK 8'h08
`define FLG_CMD_CLR_LOCK 8'h09
`define FLG_CMD_SET_GP 8'h0B
`define FLG_CMD_GET_DESC 8'h0E
`define FLG_ST_READY 0
`define FLG_ST_LOCK_ERR 1
`define FLG_ST_CMD_ERR 2
`define FLG_ST_SECURE 3
`define FLG_OP_PROG 2'h1
`define FLG_OP_ERASE_PAGE 2'h2
`define FLG_OP_ERASE_ALL 2'h3
`define FLG_PAGES_PER_REGION_LOG2 6
`define FLG_REGION_BYTES 32'h0000_4000
`define FLG_PAGES_PER_REGION 32'h0000_0040
`define FLG_PAGE_BYTES 32'h0000_0100
`define FLG_RESET_WORD 32'h0000_0000
`endif

// ### core/flg_pkg.sv
// Purpose: Types shared by the flash lock guard.
// Assumes: Constants come from the map header.
// Notes: States are one-hot.
`default_nettype none
package flg_pkg;
  typedef logic [31:0] flg_word_t;
  typedef enum logic [1:0] {
    flg_st_idle = 2'h1,
    flg_st_busy = 2'h2
  } flg_state_e;
endpackage
`default_nettype wire

// ### test/tb_flg_guard.sv
// Purpose: Self-checking bench for the flash lock and security guard.
// Assumes: Avalon-MM master tasks; erase filter shortened to 8 cycles.
// Notes: Calibration word and identifier values below are arbitrary.
`include "flg_map.svh"
`default_nettype none
module tb_flg_guard;
  timeunit 1ns;
  timeprecision 100ps;
  import flg_pkg::*;
  localparam flg_word_t CAL = 32'h0000_1234;
  localparam logic [127:0] UID = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
  localparam flg_word_t DESC [4] = '{32'h0000_0010, `FLG_REGION_BYTES,
    `FLG_PAGES_PER_REGION, `FLG_PAGE_BYTES};
  logic ref_clk_in, rst_b_in, avs_read_in, avs_write_in, erase_pin_in;
  logic nvm_secure_in, flash_done_in, dbg_req_in, ffpi_req_in;
  logic avs_waitrequest_out, dbg_grant_out, ffpi_grant_out, flash_start_out;
  logic secure_out, irq_out;
  logic [7:0] avs_address_in;
  logic [3:0] avs_byteenable_in, flash_wait_out;
  flg_word_t avs_writedata_in, avs_readdata_out, rd_q;
  logic [1:0] flash_op_out, op_s;
  logic [15:0] flash_page_out, nvm_lock_in, lock_bits_out, pg_s;
  int n_errors, samples_checked, cyc, nst;

  flg_guard #(.NUM_REGIONS(16), .ERASE_QUAL_CYC(8), .CALIB_WORD(CAL),
    .UNIQUE_ID(UID)) flg_guard_i (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .erase_pin_in(erase_pin_in),
    .nvm_secure_in(nvm_secure_in), .nvm_lock_in(nvm_lock_in),
    .flash_done_in(flash_done_in), .dbg_req_in(dbg_req_in),
    .ffpi_req_in(ffpi_req_in), .dbg_grant_out(dbg_grant_out),
    .ffpi_grant_out(ffpi_grant_out), .flash_start_out(flash_start_out),
    .flash_op_out(flash_op_out), .flash_page_out(flash_page_out),
    .flash_wait_out(flash_wait_out), .lock_bits_out(lock_bits_out),
    .secure_out(secure_out), .irq_out(irq_out));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task give_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hang in any wait loop ends here as a failure.
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      give_verdict;
    end
  end

  task chk(input string what, input flg_word_t seen, input flg_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request is held until waitrequest is sampled low, then released.
  task bus(input logic wr, input logic [7:0] a, input flg_word_t d);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd_q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task rd_chk(input string what, input logic [7:0] a, input flg_word_t exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, rd_q, exp);
  endtask

  task cmd(input logic [7:0] key, input logic [15:0] arg);
    bus(1'b1, `FLG_REG_CMD, {arg, 8'h00, key});
  endtask

  // Counts start pulses, sampling each cycle after the edge has settled.
  task starts(input int n);
    nst = 0;
    repeat (n) begin
      #1;
      if (flash_start_out === 1'b1) begin
        nst++;
        op_s = flash_op_out;
        pg_s = flash_page_out;
      end
      @(posedge ref_clk_in);
    end
  endtask

  task done_pulse;
    @(posedge ref_clk_in);
    flash_done_in <= 1'b1;
    @(posedge ref_clk_in);
    flash_done_in <= 1'b0;
  endtask

  task grants(input logic exp);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("grants", {30'h0, dbg_grant_out, ffpi_grant_out}, {30'h0, exp, exp});
  endtask

  initial begin
    rst_b_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 8'h00;
    avs_byteenable_in = 4'hF;
    avs_writedata_in = 32'h0000_0000;
    erase_pin_in = 1'b0;
    nvm_secure_in = 1'b0;
    nvm_lock_in = 16'h0001;
    flash_done_in = 1'b0;
    dbg_req_in = 1'b1;
    ffpi_req_in = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    grants(1'b1);
    rd_chk("lock", `FLG_REG_LOCK, 32'h0000_0001);
    rd_chk("status", `FLG_REG_STATUS, 32'h0000_0001);
    bus(1'b1, `FLG_REG_CTRL, 32'h0000_0003);
    #1;
    chk("wait", {28'h0, flash_wait_out}, 32'h0000_0003);
    rd_chk("calib", `FLG_REG_CALIB, CAL);
    bus(1'b1, `FLG_REG_CALIB, ~CAL);
    rd_chk("calib", `FLG_REG_CALIB, CAL);
    for (int i = 0; i < 4; i++) begin
      rd_chk("uid", `FLG_REG_UID0 + 8'(4*i), UID[32*i +: 32]);
      cmd(`FLG_CMD_GET_DESC, 16'(i));
      rd_chk("descriptor", `FLG_REG_RESULT, DESC[i]);
    end
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    // Last page of the locked region 0 must be refused.
    cmd(`FLG_CMD_PROG, 16'd63);
    starts(4);
    chk("locked start", 32'(nst), 32'h0000_0000);
    chk("irq", {31'h0, irq_out}, 32'h0000_0001);
    rd_chk("status", `FLG_REG_STATUS, 32'h0000_0003);
    #1;
    chk("irq", {31'h0, irq_out}, 32'h0000_0000);
    cmd(`FLG_CMD_PROG, 16'd64);
    starts(4);
    chk("start", 32'({op_s, pg_s}), 32'({`FLG_OP_PROG, 16'd64}));
    chk("starts", 32'(nst), 32'h0000_0001);
    // A command while busy is refused and flagged.
    cmd(`FLG_CMD_SET_LOCK, 16'd64);
    rd_chk("busy", `FLG_REG_STATUS, 32'h0000_0004);
    done_pulse;
    rd_chk("idle", `FLG_REG_STATUS, 32'h0000_0001);
    cmd(`FLG_CMD_CLR_LOCK, 16'd0);
    rd_chk("lock", `FLG_REG_LOCK, 32'h0000_0000);
    cmd(`FLG_CMD_ERASE_PAGE, 16'd5);
    starts(4);
    chk("unlocked start", 32'(nst), 32'h0000_0001);
    chk("erase", 32'(op_s), 32'(`FLG_OP_ERASE_PAGE));
    chk("page", 32'(pg_s), 32'h0000_0005);
    done_pulse;
    cmd(`FLG_CMD_SET_LOCK, 16'd0);
    rd_chk("lock", `FLG_REG_LOCK, 32'h0000_0001);
    cmd(`FLG_CMD_ERASE_PAGE, 16'd10);
    starts(4);
    chk("locked erase", 32'(nst), 32'h0000_0000);
    // A partial command write must not act.
    avs_byteenable_in <= 4'h3;
    cmd(`FLG_CMD_CLR_LOCK, 16'd0);
    avs_byteenable_in <= 4'hF;
    rd_chk("partial", `FLG_REG_STATUS, 32'h0000_0007);
    chk("lock bits", {16'h0, lock_bits_out}, 32'h0000_0001);
    cmd(`FLG_CMD_SET_GP, 16'd1);
    rd_chk("bad gp", `FLG_REG_STATUS, 32'h0000_0005);
    cmd(`FLG_CMD_SET_GP, 16'd0);
    rd_chk("secure", `FLG_REG_STATUS, 32'h0000_0009);
    grants(1'b0);
    // A pulse shorter than the filter must leave the locks alone.
    @(posedge ref_clk_in);
    erase_pin_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    erase_pin_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    rd_chk("glitch lock", `FLG_REG_LOCK, 32'h0000_0001);
    erase_pin_in <= 1'b1;
    starts(30);
    erase_pin_in <= 1'b0;
    chk("pin erase", {30'h0, op_s}, {30'h0, `FLG_OP_ERASE_ALL});
    chk("pin starts", 32'(nst), 32'h0000_0001);
    chk("lock bits", {16'h0, lock_bits_out}, 32'h0000_0000);
    rd_chk("pin lock", `FLG_REG_LOCK, 32'h0000_0000);
    chk("still secure", {31'h0, secure_out}, 32'h0000_0001);
    grants(1'b0);
    done_pulse;
    grants(1'b1);
    chk("unsecured", {31'h0, secure_out}, 32'h0000_0000);
    // A full erase without the pin leaves security set.
    cmd(`FLG_CMD_SET_GP, 16'd0);
    cmd(`FLG_CMD_ERASE_ALL, 16'd0);
    starts(4);
    chk("erase all", {30'h0, op_s}, {30'h0, `FLG_OP_ERASE_ALL});
    chk("all starts", 32'(nst), 32'h0000_0001);
    done_pulse;
    #1;
    chk("kept secure", {31'h0, secure_out}, 32'h0000_0001);
    rd_chk("calib", `FLG_REG_CALIB, CAL);
    rd_chk("uid", `FLG_REG_UID3, UID[127:96]);
    give_verdict;
  end
endmodule
`default_nettype wire
